//--- hw/rtcirq_sync.sv
// Three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/1ps
module rtcirq_sync
   import rtcirq_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Level in and out
   input wire logic async_in,
   output logic level
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } rtcirq_sync_t;

   rtcirq_sync_t s;
   rtcirq_sync_t next_s;

   always_comb begin
      next_s = s;
      next_s.s1 = async_in;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      // Only a value seen on two later stages counts
      if (s.s2 == s.s3) begin
         next_s.level = s.s3;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign level = s.level;

endmodule : rtcirq_sync

//--- hw/rtcirq_tick.sv
// Counter clock tick generator with prescaler frequency trim
`timescale 1ns/1ps
module rtcirq_tick
   import rtcirq_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic run,
   input wire logic trim_sign,
   input wire logic [6:0] trim_mag,
   // Counter clock tick
   output logic tick
);

   typedef struct packed {
      logic [7:0] cnt;
      logic [6:0] acc;
      logic tick;
   } rtcirq_tick_t;

   rtcirq_tick_t s;
   rtcirq_tick_t next_s;
   logic [7:0] sum;

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      sum = {1'b0, s.acc} + {1'b0, trim_mag};
      if (!run) begin
         next_s.cnt = TICK_LEN - 8'h01;
      end else if (s.cnt == 8'h00) begin
         next_s.tick = 1'b1;
         // Spread the trim as one stretched or shortened period
         next_s.acc = sum[6:0];
         if (sum[7]) begin
            // Sign zero shortens the period, raising the frequency
            next_s.cnt = trim_sign ? TICK_LEN : TICK_LEN - 8'h02;
         end else begin
            next_s.cnt = TICK_LEN - 8'h01;
         end
      end else begin
         next_s.cnt = s.cnt - 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;

endmodule : rtcirq_tick

//--- hw/rtcirq_top.sv
// Interrupt, status, debug and trim registers of the real time counter
`timescale 1ns/1ps

module rtcirq_top
   import rtcirq_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Counter events, one-cycle pulses
   input wire logic overflow_evt,
   input wire logic [1:0] compare_evt,
   input wire logic alarm_evt,
   // Processor debug state, asynchronous
   input wire logic debug_halt,
   // Counter side
   output logic count_tick,
   output logic count_enable,
   output logic [1:0] count_mode,
   // Interrupt
   output logic irq
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic en_req;
      logic en_live;
      logic [1:0] mode;
      logic [7:0] ien;
      logic [7:0] flags;
      logic [7:0] pend;
      logic busy;
      logic busy_prev;
      logic quiet;
      logic [3:0] sync_cnt;
      logic run_debug;
      logic [7:0] trim_req;
      logic [7:0] trim_live;
      logic [31:0] prdata;
      logic perr;
   } rtcirq_state_t;

   rtcirq_state_t s;
   rtcirq_state_t next_s;

   logic dbg_level;
   logic tick;
   logic [7:0] mask;
   logic [7:0] evt;
   logic [7:0] wdat;
   logic [7:0] clr;
   logic [7:0] setv;
   logic setup;
   logic access;
   logic wr;
   logic run;

   // ------------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------------
   rtcirq_sync u_dbg_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(debug_halt),
      .level(dbg_level)
   );

   // Debug halt gates the prescaler itself, so no tick is lost or faked
   assign run = s.en_live & (~dbg_level | s.run_debug);

   rtcirq_tick u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .trim_sign(s.trim_live[BIT_SIGN]),
      .trim_mag(s.trim_live[6:0]),
      .tick(tick)
   );

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr = access & pwrite;
   assign wdat = pwdata[7:0];
   assign mask = rtcirq_mask(s.mode);

   // ------------------------------------------------------------------
   // Event mapping per mode
   // ------------------------------------------------------------------
   always_comb begin
      evt = 8'h00;
      evt[BIT_OVERFLOW] = overflow_evt;
      if (s.mode == 2'(calendar_mode)) begin
         evt[BIT_COMPARE_ZERO] = alarm_evt;
      end else begin
         evt[BIT_COMPARE_ZERO] = compare_evt[0];
         evt[BIT_COMPARE_ONE] = compare_evt[1];
      end
      evt = s.en_live ? (evt & mask) : 8'h00;
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      next_s = s;
      clr = 8'h00;
      setv = 8'h00;

      // Events wait for the next counter clock tick
      next_s.pend = s.pend | evt;
      if (tick) begin
         setv = s.pend;
         next_s.pend = evt;
      end

      // Synchronisation busy window
      next_s.busy_prev = s.busy;
      if (s.busy) begin
         if (s.sync_cnt == 4'h0) begin
            next_s.busy = 1'b0;
            next_s.en_live = s.en_req;
            next_s.trim_live = s.trim_req;
         end else begin
            next_s.sync_cnt = s.sync_cnt - 4'h1;
         end
      end
      // Enable or reset caused falls stay silent
      if (s.busy_prev & ~s.busy & ~s.quiet) begin
         setv[BIT_SYNC_DONE] = 1'b1;
      end

      // Read data captured in the setup cycle
      if (setup) begin
         next_s.perr = 1'b0;
         next_s.prdata = 32'h0000_0000;
         case (paddr)
            ADDR_CTRL: begin
               next_s.prdata[MODE_LSB +: 2] = s.mode;
               next_s.prdata[BIT_ENABLE] = s.en_req;
            end
            ADDR_IEN_CLR,
            ADDR_IEN_SET: begin
               next_s.prdata[7:0] = s.ien & mask;
            end
            ADDR_FLAGS: begin
               next_s.prdata[7:0] = s.flags & mask;
            end
            ADDR_STATUS: begin
               next_s.prdata[BIT_BUSY] = s.busy;
            end
            ADDR_DEBUG: begin
               next_s.prdata[BIT_RUN_DEBUG] = s.run_debug;
            end
            ADDR_TRIM: begin
               next_s.prdata[7:0] = s.trim_req;
            end
            default: begin
               next_s.perr = 1'b1;
            end
         endcase
      end

      // Writes take effect at the access edge
      if (wr) begin
         case (paddr)
            ADDR_CTRL: begin
               if (wdat[BIT_SWRST]) begin
                  // Software reset leaves run-in-debug alone
                  next_s.en_req = 1'b0;
                  next_s.en_live = 1'b0;
                  next_s.mode = 2'(count32_mode);
                  next_s.ien = RST_IEN;
                  next_s.pend = 8'h00;
                  next_s.trim_req = RST_TRIM;
                  next_s.trim_live = RST_TRIM;
                  clr = 8'hFF;
                  setv = 8'h00;
                  next_s.busy = 1'b1;
                  next_s.quiet = 1'b1;
                  next_s.sync_cnt = SYNC_LEN;
               end else begin
                  next_s.mode = wdat[MODE_LSB +: 2];
                  next_s.en_req = wdat[BIT_ENABLE];
                  next_s.busy = 1'b1;
                  next_s.quiet = wdat[BIT_ENABLE] ^ s.en_req;
                  next_s.sync_cnt = SYNC_LEN;
               end
            end
            ADDR_IEN_SET: begin
               next_s.ien = s.ien | (wdat & mask);
            end
            ADDR_IEN_CLR: begin
               next_s.ien = s.ien & ~(wdat & mask);
            end
            ADDR_FLAGS: begin
               clr = wdat & mask;
            end
            ADDR_DEBUG: begin
               next_s.run_debug = wdat[BIT_RUN_DEBUG];
            end
            ADDR_TRIM: begin
               next_s.trim_req = wdat;
               next_s.busy = 1'b1;
               next_s.quiet = 1'b0;
               next_s.sync_cnt = SYNC_LEN;
            end
            default: begin
               next_s.perr = s.perr;
            end
         endcase
      end

      // A flag raised in a flags clear cycle survives; a software reset drops it
      next_s.flags = (s.flags & ~clr) | setv;
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.flags <= RST_FLAGS;
         s.run_debug <= RST_RUN_DEBUG;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign prdata = s.prdata;
   assign pready = access;
   assign pslverr = access & s.perr;
   assign count_tick = tick;
   assign count_enable = run;
   assign count_mode = s.mode;
   assign irq = |(s.flags & s.ien & mask);

endmodule : rtcirq_top

//--- inc/rtcirq_pkg.sv
// Constants, types and decode helpers shared by the counter interrupt block
package rtcirq_pkg;

   // ------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [7:0] IDX_CTRL = 8'h00;
   localparam logic [7:0] IDX_IEN_CLR = 8'h06;
   localparam logic [7:0] IDX_IEN_SET = 8'h07;
   localparam logic [7:0] IDX_FLAGS = 8'h08;
   localparam logic [7:0] IDX_STATUS = 8'h0A;
   localparam logic [7:0] IDX_DEBUG = 8'h0B;
   localparam logic [7:0] IDX_TRIM = 8'h0C;

   localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
   localparam logic [7:0] ADDR_IEN_CLR = {IDX_IEN_CLR[5:0], 2'b00};
   localparam logic [7:0] ADDR_IEN_SET = {IDX_IEN_SET[5:0], 2'b00};
   localparam logic [7:0] ADDR_FLAGS = {IDX_FLAGS[5:0], 2'b00};
   localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'b00};
   localparam logic [7:0] ADDR_DEBUG = {IDX_DEBUG[5:0], 2'b00};
   localparam logic [7:0] ADDR_TRIM = {IDX_TRIM[5:0], 2'b00};

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int unsigned BIT_OVERFLOW = 7;
   localparam int unsigned BIT_SYNC_DONE = 6;
   localparam int unsigned BIT_COMPARE_ONE = 1;
   localparam int unsigned BIT_COMPARE_ZERO = 0;
   localparam int unsigned BIT_BUSY = 7;
   localparam int unsigned BIT_RUN_DEBUG = 0;
   localparam int unsigned BIT_SIGN = 7;
   localparam int unsigned BIT_SWRST = 0;
   localparam int unsigned BIT_ENABLE = 1;
   localparam int unsigned MODE_LSB = 2;

   // Implemented flag and enable bits per mode
   localparam logic [7:0] MASK_COUNT32 = 8'hC1;
   localparam logic [7:0] MASK_COUNT16 = 8'hC3;
   localparam logic [7:0] MASK_CALENDAR = 8'hC1;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_IEN = 8'h00;
   localparam logic [7:0] RST_TRIM = 8'h00;
   localparam logic RST_RUN_DEBUG = 1'b0;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned TICK_PERIOD_NS = 1000;
   localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [7:0] TICK_LEN = 8'(TICK_CYCLES);
   localparam int unsigned SYNC_TIME_NS = 100;
   localparam int unsigned SYNC_CYCLES =
      (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] SYNC_LEN = 4'(SYNC_CYCLES);

   // ------------------------------------------------------------------
   // Types and decode
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      count32_mode,
      count16_mode,
      calendar_mode
   } rtcirq_mode_t;

   function automatic logic [7:0] rtcirq_mask(input logic [1:0] mode);
      case (mode)
         2'h1: rtcirq_mask = MASK_COUNT16;
         2'h2: rtcirq_mask = MASK_CALENDAR;
         default: rtcirq_mask = MASK_COUNT32;
      endcase
   endfunction : rtcirq_mask

endpackage : rtcirq_pkg

//--- verif/rtcirq_props.sv
// Port-level assertions for the counter interrupt block
`timescale 1ns/1ps
module rtcirq_props
   import rtcirq_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Counter side and interrupt
   input wire logic count_tick,
   input wire logic count_enable,
   input wire logic [1:0] count_mode,
   input wire logic irq
);
   // ----
   // Access decode
   // ----
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic acc;
   logic hit;
   logic wctl;
   assign acc = psel && penable;
   assign hit = paddr inside {ADDR_CTRL, ADDR_IEN_CLR, ADDR_IEN_SET,
      ADDR_FLAGS, ADDR_STATUS, ADDR_DEBUG, ADDR_TRIM};
   assign wctl = acc && pwrite && paddr == ADDR_CTRL;
   // ----
   // Properties
   // ----
   property p_ready;
      acc |-> pready && (pslverr == !hit);
   endproperty
   a_ready: assert property (p_ready)
      else $error("pready or pslverr wrong in access");
   property p_idle;
      !acc |-> !pready && !pslverr;
   endproperty
   a_idle: assert property (p_idle)
      else $error("pready or pslverr outside access");
   property p_rdhi;
      acc && !pwrite |-> prdata[31:8] == 24'h0 && (hit || prdata == 0);
   endproperty
   a_rdhi: assert property (p_rdhi)
      else $error("reserved read bits not zero");
   property p_ienclr;
      acc && pwrite && paddr == ADDR_IEN_CLR && pwdata[7:0] == 8'hFF
         |-> ##[1:2] !irq;
   endproperty
   a_ienclr: assert property (p_ienclr)
      else $error("irq stays after all enables cleared");
   property p_gap;
      count_tick |=> !count_tick [*8];
   endproperty
   a_gap: assert property (p_gap)
      else $error("counter ticks too close");
   property p_halt;
      !count_enable [*3] |-> !count_tick;
   endproperty
   a_halt: assert property (p_halt)
      else $error("tick while counter stopped");
   property p_swrst;
      wctl && pwdata[BIT_SWRST] |-> ##[1:10] !irq && !count_enable;
   endproperty
   a_swrst: assert property (p_swrst)
      else $error("software reset left irq or enable");
   property p_mode;
      wctl && !pwdata[BIT_SWRST] |=> count_mode == $past(pwdata[3:2]);
   endproperty
   a_mode: assert property (p_mode)
      else $error("mode not applied");
endmodule : rtcirq_props

bind rtcirq_top rtcirq_props props_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .count_tick(count_tick), .count_enable(count_enable),
   .count_mode(count_mode), .irq(irq));

//--- verif/test_rtcirq_top.sv
// Directed APB bench for the counter interrupt block
`timescale 1ns/1ps
module test_rtcirq_top
   import rtcirq_pkg::*;
   ;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, rerr, count_tick, count_enable, irq;
   logic overflow_evt = 0, alarm_evt = 0, debug_halt = 0;
   logic [1:0] compare_evt = 2'b00, count_mode;
   int fails = 0, num_checks = 0;
   always #10 pclk = ~pclk;
   rtcirq_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .overflow_evt(overflow_evt), .compare_evt(compare_evt),
      .alarm_evt(alarm_evt), .debug_halt(debug_halt),
      .count_tick(count_tick), .count_enable(count_enable),
      .count_mode(count_mode), .irq(irq));
   // ----
   // Tasks
   // ----
   task summarize;
      if (fails == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task lim(input int n);
      if (n >= 200) begin
         fails++;
         summarize();
      end
   endtask : lim
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Request held until pready is seen at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 200);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      lim(n);
   endtask : apb
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr
   task rd(input string nm, input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, {24'h0, e}, rdat);
   endtask : rd
   // Two falling edges let a registered irq settle
   task irqc(input logic e);
      @(negedge pclk);
      @(negedge pclk);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask : irqc
   task sync_wait;
      int n;
      n = 0;
      do begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         n++;
      end while (rdat[BIT_BUSY] !== 1'b0 && n < 200);
      lim(n);
   endtask : sync_wait
   // Events only count once the next counter tick has passed
   task pulse(input logic o, input logic [1:0] c, input logic a);
      int n;
      n = 0;
      @(posedge pclk);
      overflow_evt <= o;
      compare_evt <= c;
      alarm_evt <= a;
      @(posedge pclk);
      overflow_evt <= 1'b0;
      compare_evt <= 2'b00;
      alarm_evt <= 1'b0;
      do begin
         @(negedge pclk);
         n++;
      end while (count_tick !== 1'b1 && n < 200);
      lim(n);
      repeat (3) @(posedge pclk);
   endtask : pulse
   // ----
   // Sequence
   // ----
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd("ien", ADDR_IEN_SET, 8'h00);
      rd("flags", ADDR_FLAGS, 8'h00);
      rd("status", ADDR_STATUS, 8'h00);
      rd("debug", ADDR_DEBUG, 8'h00);
      rd("trim", ADDR_TRIM, 8'h00);
      rd("unmapped", 8'h04, 8'h00);
      chk("pslverr", 32'h1, {31'h0, rerr});
      wr(ADDR_CTRL, 8'h06);
      rd("status", ADDR_STATUS, 8'h80);
      sync_wait();
      rd("flags", ADDR_FLAGS, 8'h00);
      chk("count_enable", 32'h1, {31'h0, count_enable});
      wr(ADDR_TRIM, 8'h85);
      sync_wait();
      rd("flags", ADDR_FLAGS, 8'h40);
      rd("trim", ADDR_TRIM, 8'h85);
      wr(ADDR_DEBUG, 8'hFE);
      rd("debug", ADDR_DEBUG, 8'h00);
      irqc(1'b0);
      wr(ADDR_IEN_SET, 8'h40);
      irqc(1'b1);
      wr(ADDR_FLAGS, 8'h00);
      rd("flags", ADDR_FLAGS, 8'h40);
      wr(ADDR_IEN_CLR, 8'hFF);
      irqc(1'b0);
      rd("ien", ADDR_IEN_CLR, 8'h00);
      wr(ADDR_IEN_SET, 8'h40);
      wr(ADDR_FLAGS, 8'h40);
      irqc(1'b0);
      pulse(1'b1, 2'b11, 1'b0);
      rd("flags", ADDR_FLAGS, 8'h83);
      wr(ADDR_IEN_SET, 8'h80);
      irqc(1'b1);
      wr(ADDR_FLAGS, 8'hFF);
      irqc(1'b0);
      wr(ADDR_CTRL, 8'h0A);
      sync_wait();
      rd("flags", ADDR_FLAGS, 8'h40);
      wr(ADDR_FLAGS, 8'h40);
      pulse(1'b0, 2'b10, 1'b1);
      rd("flags", ADDR_FLAGS, 8'h01);
      wr(ADDR_IEN_SET, 8'h01);
      rd("ien", ADDR_IEN_SET, 8'hC1);
      irqc(1'b1);
      chk("count_mode", 32'h2, {30'h0, count_mode});
      @(posedge pclk);
      debug_halt <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("count_enable", 32'h0, {31'h0, count_enable});
      wr(ADDR_DEBUG, 8'h01);
      repeat (8) @(posedge pclk);
      chk("count_enable", 32'h1, {31'h0, count_enable});
      debug_halt <= 1'b0;
      wr(ADDR_CTRL, 8'h01);
      sync_wait();
      rd("debug", ADDR_DEBUG, 8'h01);
      rd("flags", ADDR_FLAGS, 8'h00);
      rd("ien", ADDR_IEN_SET, 8'h00);
      irqc(1'b0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd("debug", ADDR_DEBUG, 8'h00);
      summarize();
   end
endmodule : test_rtcirq_top
